/* File: common/asr_pkg.sv */
// Purpose: Constants and carrier types for the async 16-bit SRAM host controller.
// Assumes: 25 MHz controller clock (40 ns period).
// Notes:   Cycle counts are derived from the printed times, rounded up.
// Operation
// - Write happens only while strobe, both chip selects and a byte select overlap.
// - Write data valid 25 ns before write end, held 0 ns after.
// - Address and chip selects stable 45 ns before the write-ending edge.
// - Address valid at write start, may change only after write ends.
// - Byte select low 45 ns, strobe pulse 40 ns, writes 55 ns apart.
// - Deselected when either chip select inactive or both byte selects high.
// - Write strobe stays high for the whole of every read.
// - Address valid no later than chip and byte selects going active.
// - Deselect before retention; wait 55 ns after retention before access.
// - Controller never drives data pins while the memory drives them.
package asr_pkg;
  localparam int unsigned CLK_PERIOD_NS            = 40;
  localparam int unsigned ADDR_W                   = 22;
  localparam int unsigned DATA_W                   = 16;
  localparam int unsigned READ_CYCLE_MIN_NS        = 55;
  localparam int unsigned ADDR_ACCESS_DELAY_NS     = 55;
  localparam int unsigned OUT_ENABLE_ACCESS_NS     = 25;
  localparam int unsigned BYTE_SEL_TURNOFF_NS      = 20;
  localparam int unsigned WRITE_CYCLE_MIN_NS       = 55;
  localparam int unsigned ADDR_SETUP_TO_WR_END_NS  = 45;
  localparam int unsigned WRITE_PULSE_MIN_NS       = 40;
  localparam int unsigned DATA_SETUP_TO_WR_END_NS  = 25;
  localparam int unsigned RETENTION_RECOVERY_NS    = 55;

  function automatic int unsigned cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Write pulse must satisfy strobe width, address/select setup and data setup
  localparam int unsigned WR_PULSE_CYC = cyc(ADDR_SETUP_TO_WR_END_NS);
  localparam int unsigned WR_CYCLE_CYC = cyc(WRITE_CYCLE_MIN_NS);
  // Read sample after access time; one extra cycle covers output enable path
  localparam int unsigned RD_ACCESS_CYC = cyc(ADDR_ACCESS_DELAY_NS);
  localparam int unsigned RD_CYCLE_CYC  = cyc(READ_CYCLE_MIN_NS);
  localparam int unsigned TURNOFF_CYC   = cyc(BYTE_SEL_TURNOFF_NS);
  localparam int unsigned RECOVERY_CYC  = cyc(RETENTION_RECOVERY_NS);
  localparam int unsigned CNT_W         = 3;

  typedef struct packed {
    logic              write;
    logic [1:0]        byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic              chip_select_n;
    logic              chip_select_hi;
    logic              write_strobe_n;
    logic              out_enable_n;
    logic              upper_byte_sel_n;
    logic              lower_byte_sel_n;
    logic [ADDR_W-1:0] addr;
  } asr_pins_t;
endpackage

/* File: verilog/asr_dq_lane.sv */
// Purpose: Data pin buffer for one byte lane: output register and input sync.
// Assumes: Memory data pins are asynchronous to clk_i.
// Notes:   Input passes two flip-flops before the controller samples it.
module asr_dq_lane (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Controller side
  input  wire logic       load_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       drive_i,
  output logic      [7:0] rdata_o,
  // Pin side
  input  wire logic [7:0] dq_i,
  output logic      [7:0] dq_o,
  output logic      [7:0] dq_oe_o
);
  logic [7:0] sync1;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1   <= 8'h00;
      rdata_o <= 8'h00;
    end else begin
      sync1   <= dq_i;
      rdata_o <= sync1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_o <= 8'h00;
    end else if (load_i) begin
      dq_o <= wdata_i;
    end
  end

  // Unselected lane never drives
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dq_oe_o <= 8'h00;
    end else begin
      dq_oe_o <= {8{drive_i}};
    end
  end
endmodule

/* File: verilog/asr_host.sv */
// Purpose: Clocked host controller driving an asynchronous 16-bit SRAM.
// Assumes: One request at a time; req_ready_o high only in idle.
// Notes:   Each access holds address and selects for the whole cycle.
module asr_host (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  // Request port
  input  wire logic                     req_valid_i,
  input  wire asr_pkg::asr_req_t        req_i,
  output logic                          req_ready_o,
  // Read answer
  output logic                          rsp_valid_o,
  output logic [asr_pkg::DATA_W-1:0]    rsp_rdata_o,
  // Retention control
  input  wire logic                     retention_i,
  output logic                          retention_ok_o,
  // Memory pins
  output asr_pkg::asr_pins_t            pins_o,
  input  wire logic [asr_pkg::DATA_W-1:0] dq_i,
  output logic [asr_pkg::DATA_W-1:0]    dq_o,
  output logic [asr_pkg::DATA_W-1:0]    dq_oe_o
);
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_WRITE  = 6'h02,
    ST_WREC   = 6'h04,
    ST_READ   = 6'h08,
    ST_RTAIL  = 6'h10,
    ST_RETAIN = 6'h20
  } asr_state_t;

  asr_state_t                   state;
  asr_state_t                   next_state;
  logic [asr_pkg::CNT_W-1:0]    cnt;
  logic [asr_pkg::CNT_W-1:0]    next_cnt;
  asr_pkg::asr_req_t            cur;
  logic [asr_pkg::DATA_W-1:0]   lane_rdata;
  logic                         ret_s1;
  logic                         ret_s2;
  logic                         start;

  ////////////////////////////////////////////////////////////////////////////
  // Retention request synchroniser (comes from outside the clock domain)
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ret_s1 <= 1'b0;
      ret_s2 <= 1'b0;
    end else begin
      ret_s1 <= retention_i;
      ret_s2 <= ret_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign req_ready_o = (state == ST_IDLE) && !ret_s2;
  assign start       = req_valid_i && req_ready_o;

  always_comb begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
    case (state)
      ST_IDLE: begin
        if (ret_s2) begin
          next_state = ST_RETAIN;                  // Already deselected
        end else if (start && req_i.write) begin
          next_state = ST_WRITE;
          next_cnt   = asr_pkg::CNT_W'(asr_pkg::WR_PULSE_CYC - 1);
        end else if (start) begin
          next_state = ST_READ;
          next_cnt   = asr_pkg::CNT_W'(asr_pkg::RD_ACCESS_CYC);
        end
      end
      ST_WRITE: begin
        if (cnt == '0) begin
          next_state = ST_WREC;
          next_cnt   = asr_pkg::CNT_W'(asr_pkg::WR_CYCLE_CYC - asr_pkg::WR_PULSE_CYC);
        end
      end
      ST_WREC: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (cnt == '0) begin
          next_state = ST_RTAIL;
          next_cnt   = asr_pkg::CNT_W'(asr_pkg::TURNOFF_CYC);
        end
      end
      ST_RTAIL: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        if (!ret_s2) begin
          next_state = ST_WREC;
          next_cnt   = asr_pkg::CNT_W'(asr_pkg::RECOVERY_CYC);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Request held for the whole access so address never moves mid-cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else if (start) begin
      cur <= req_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: address and selects change together, strobe only in ST_WRITE
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_o.chip_select_n    <= 1'b1;
      pins_o.chip_select_hi   <= 1'b0;
      pins_o.write_strobe_n   <= 1'b1;
      pins_o.out_enable_n     <= 1'b1;
      pins_o.upper_byte_sel_n <= 1'b1;
      pins_o.lower_byte_sel_n <= 1'b1;
      pins_o.addr             <= '0;
    end else begin
      // Selects and strobe are all registered from next_state, so they switch on the same edge
      pins_o.chip_select_n    <= !(next_state inside {ST_WRITE, ST_READ});
      pins_o.chip_select_hi   <=  (next_state inside {ST_WRITE, ST_READ});
      pins_o.write_strobe_n   <= !(next_state == ST_WRITE);
      pins_o.out_enable_n     <= !(next_state == ST_READ);
      pins_o.upper_byte_sel_n <= !((next_state inside {ST_WRITE, ST_READ}) &&
                                   (start ? req_i.byte_en[1] : cur.byte_en[1]));
      pins_o.lower_byte_sel_n <= !((next_state inside {ST_WRITE, ST_READ}) &&
                                   (start ? req_i.byte_en[0] : cur.byte_en[0]));
      if (start) begin
        pins_o.addr <= req_i.addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data lanes: drive only during a write, never while output enable is low
  for (genvar g = 0; g < 2; g++) begin : g_lane
    asr_dq_lane u_lane (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .load_i  (start),
      .wdata_i (req_i.wdata[8*g +: 8]),
      .drive_i (next_state == ST_WRITE && (start ? req_i.byte_en[g] : cur.byte_en[g])),
      .rdata_o (lane_rdata[8*g +: 8]),
      .dq_i    (dq_i[8*g +: 8]),
      .dq_o    (dq_o[8*g +: 8]),
      .dq_oe_o (dq_oe_o[8*g +: 8])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answer: sampled through the two-stage lane synchroniser
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= (state == ST_RTAIL) && (cnt == asr_pkg::CNT_W'(asr_pkg::TURNOFF_CYC));
      if ((state == ST_RTAIL) && (cnt == asr_pkg::CNT_W'(asr_pkg::TURNOFF_CYC))) begin
        rsp_rdata_o <= lane_rdata & {{8{cur.byte_en[1]}}, {8{cur.byte_en[0]}}};
      end
    end
  end

  assign retention_ok_o = (state == ST_RETAIN);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_wr_start;
    $fell(pins_o.write_strobe_n);
  endsequence

  chk_strobe_width: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_wr_start |-> !pins_o.write_strobe_n [*2])
    else $error("write strobe pulse too short");
  chk_write_overlap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !pins_o.write_strobe_n |-> !pins_o.chip_select_n && pins_o.chip_select_hi &&
      !(pins_o.upper_byte_sel_n && pins_o.lower_byte_sel_n))
    else $error("write strobe without full select");
  chk_addr_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !pins_o.write_strobe_n |=> $stable(pins_o.addr))
    else $error("address moved during write");
  chk_read_no_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !pins_o.out_enable_n |-> dq_oe_o == '0)
    else $error("data driven while memory outputs enabled");
  chk_read_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !pins_o.out_enable_n |-> pins_o.write_strobe_n)
    else $error("write strobe low during read");
  chk_write_spacing: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(pins_o.write_strobe_n) |-> pins_o.write_strobe_n [*2])
    else $error("writes too close");
  chk_retain_desel: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    retention_ok_o |-> pins_o.chip_select_n && !pins_o.chip_select_hi)
    else $error("retention while selected");
  chk_read_answer: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(pins_o.out_enable_n) |-> ##[3:4] rsp_valid_o)
    else $error("read answer not on time");
endmodule

/* File: sim/asr_sram_model.sv */
// Purpose: Behavioural async 16-bit SRAM that also checks host write timing.
// Assumes: Pin delays in ns; slow_i selects worst-case access time.
// Notes:   Undriven data lines toggle so a stale sample cannot pass.
module asr_sram_model (
  // Host pins
  input  wire asr_pkg::asr_pins_t pins_i,
  input  wire logic [15:0]        dq_i,
  input  wire logic [15:0]        dq_oe_i,
  // Model control and status
  input  wire logic               slow_i,
  output logic      [15:0]        bus_o,
  output logic      [7:0]         viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  asr_pkg::asr_pins_t pd;
  logic [15:0]        mem [logic [21:0]];
  logic [15:0]        rd = 16'h0000;
  logic [15:0]        flt = 16'hA5A5;
  logic [15:0]        bus_d;
  logic [15:0]        oe_d;
  logic [1:0]         drv;
  logic               wact;
  int unsigned        seq = 0;
  realtime            t_ws = -1000.0;
  realtime            t_a = 0.0;
  realtime            t_d = 0.0;
  // Delayed copies give the values just before a write-ending edge
  assign #1 pd = pins_i;
  assign #1 bus_d = bus_o;
  assign #1 oe_d = dq_oe_i;
  initial viol_o = 8'h00;
  always #17 flt = ~flt;
  assign wact = ~pins_i.chip_select_n & pins_i.chip_select_hi & ~pins_i.write_strobe_n
              & ~(pins_i.upper_byte_sel_n & pins_i.lower_byte_sel_n);
  // Turn-off is immediate, so always faster than turn-on
  assign drv = (~pins_i.chip_select_n & pins_i.chip_select_hi & pins_i.write_strobe_n
               & ~pins_i.out_enable_n) ? ~{pins_i.upper_byte_sel_n, pins_i.lower_byte_sel_n}
               : 2'b00;
  always @(pins_i.addr or drv) begin
    seq = seq + 1;
    fork
      begin
        automatic int unsigned my = seq;
        #6;
        if (my == seq) rd = ~rd;
        #((slow_i ? 55 : 10) - 6);
        if (my == seq && mem.exists(pins_i.addr)) rd = mem[pins_i.addr];
      end
    join_none
  end
  always_comb
    for (int i = 0; i < 16; i++) bus_o[i] = dq_oe_i[i] ? dq_i[i] : (drv[i/8] ? rd[i] : flt[i]);
  always @(oe_d or drv)
    if ((oe_d & {{8{drv[1]}}, {8{drv[0]}}}) != 16'h0000) viol_o = viol_o + 8'h01;
  always @(posedge wact) begin
    if ($realtime - t_ws < 55.0) viol_o = viol_o + 8'h01;
    t_ws = $realtime;
  end
  always @(pd.addr) t_a = $realtime - 1.0;
  always @(bus_d & oe_d) t_d = $realtime - 1.0;
  always @(negedge wact)
    if (t_ws >= 0.0) begin
      if ($realtime - t_ws < 45.0 || $realtime - t_d < 25.0 || t_a > t_ws)
        viol_o = viol_o + 8'h01;
      if (!pd.lower_byte_sel_n) mem[pd.addr][7:0] = bus_d[7:0];
      if (!pd.upper_byte_sel_n) mem[pd.addr][15:8] = bus_d[15:8];
    end
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the async SRAM host controller.
// Assumes: Host and memory model meet only at the data and control pins.
// Notes:   Only fully written addresses are read back.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i = 1'b0;
  logic               rst_b_i = 1'b0;
  logic               req_valid_i = 1'b0;
  asr_pkg::asr_req_t  req_i = '0;
  logic               retention_i = 1'b0;
  logic               slow = 1'b0;
  logic               req_ready_o;
  logic               rsp_valid_o;
  logic               retention_ok_o;
  logic [15:0]        rsp_rdata_o;
  logic [15:0]        dq_o;
  logic [15:0]        dq_oe_o;
  logic [15:0]        bus;
  logic [7:0]         viol;
  asr_pkg::asr_pins_t pins_o;
  logic [15:0]        ref_mem [logic [21:0]];
  logic [15:0]        exp_q [$];
  logic [21:0]        addrs [6];
  int                 errors = 0;
  int                 total_checks = 0;
  int                 cycles = 0;
  int                 seed = 32'hbeea;
  asr_host dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .retention_i(retention_i), .retention_ok_o(retention_ok_o), .pins_o(pins_o),
    .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
  asr_sram_model sram (.pins_i(pins_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .slow_i(slow),
    .bus_o(bus), .viol_o(viol));
  initial forever #20 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Valid stays up between calls so requests run back to back
  task automatic do_req(input logic wr, input logic [1:0] be, input logic [21:0] a,
                        input logic [15:0] d);
    logic [15:0] m;
    int          n;
    m = {{8{be[1]}}, {8{be[0]}}};
    n = 0;
    req_i <= '{write: wr, byte_en: be, addr: a, wdata: d};
    req_valid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 40);
    if (req_ready_o !== 1'b1) check(32'h0, 32'h1);
    if (wr) ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
    else exp_q.push_back(ref_mem[a] & m);
  endtask
  task automatic idle(input int c);
    req_valid_i <= 1'b0;
    repeat (c) @(posedge clk_i);
  endtask
  always @(posedge clk_i)
    if (rsp_valid_o === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(32'(rsp_rdata_o), 32'(exp_q.pop_front()));
    end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    logic [1:0]  be;
    int          n;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    addrs = '{22'h000000, 22'h3FFFFF, 22'h000001, 22'h2AAAAA, 22'h155555, 22'h200000};
    for (int ph = 0; ph < 2; ph++) begin
      slow <= ph[0];
      foreach (addrs[i]) do_req(1'b1, 2'h3, addrs[i], 16'($random(seed)));
      for (int k = 0; k < 30; k++) begin
        be = 2'h1 + 2'($unsigned($random(seed)) % 3);
        do_req(k[0], be, addrs[$unsigned($random(seed)) % 6], 16'($random(seed)));
      end
      foreach (addrs[i]) do_req(1'b0, 2'h3, addrs[i], 16'h0000);
      idle(10);
      $display("test access phase %0d done", ph);
    end
    rst_b_i <= 1'b0;
    @(negedge clk_i);
    check(32'(pins_o), 32'({6'b101111, 22'h000000}));
    check(32'(dq_oe_o), 32'h0);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    idle(2);
    retention_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (retention_ok_o !== 1'b1 && n < 20);
    @(negedge clk_i);
    check(32'(retention_ok_o), 32'h1);
    check(32'({pins_o.chip_select_n | ~pins_o.chip_select_hi
              | (pins_o.upper_byte_sel_n & pins_o.lower_byte_sel_n)}), 32'h1);
    check(32'(req_ready_o), 32'h0);
    @(posedge clk_i);
    retention_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 20);
    check(32'(req_ready_o === 1'b1 && n >= 2), 32'h1);
    do_req(1'b0, 2'h3, addrs[1], 16'h0000);
    idle(10);
    $display("test reset and retention done");
    check(32'(viol), 32'h0);
    check(32'(exp_q.size()), 32'h0);
    end_of_test();
  end
endmodule
